// ### src/sleep_wake_supply_monitor.sv
// Sleep and wake sequencer with the supply-detect control and status registers.
// Assumes the core talks over a byte I/O port with the bank bit folded into addr[8].
`timescale 1ns/1ps
// Behaviour
// - Sleep bit write raises bus halt request
// - After acknowledge, second edge asserts powerdown
// - Powerdown holds flash, oscillator, filter, bandgap off
// - Any unmasked pending interrupt wakes the part
// - Wake interrupt captured on 32 kHz fall
// - Next 32 kHz rise drops powerdown
// - Following rise samples reset and low-supply comparators
// - Following fall drops halt request; core resumes
// - Wake latency about 61 to 92 us, below the 105 us limit
// - Level field picks reset threshold or disables
// - Status bit 1 shows low-supply trip
// - Status bit 0 shows precise reset trip
// - Status register read-only, live values
// - Duty field sets supply monitor on-time ratio
// - Sleep bit is control bit 3; sleep until interrupt
module sleep_wake_supply_monitor
  import sleep_wake_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [8:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_q,
  input wire logic bus_halt_ack,
  input wire logic irq_pending,
  input wire logic precise_reset_cmp,
  input wire logic low_supply_cmp,
  output logic bus_halt_request_q,
  output logic system_powerdown_q,
  output logic [1:0] cmp_level_q,
  output logic reset_request_q,
  output logic low_supply_flag_q,
  output logic precise_reset_flag_q,
  output logic monitor_on_q
);
  import sleep_wake_pkg::*;

  lp_tick_if lp_tick ();

  logic ack_s;
  logic irq_s;
  logic prec_s;
  logic lvd_s;

  lp_tick_gen #(.DIV(LP_DIV)) u_tick (
    .clk(clk),
    .resetn(resetn),
    .tick(lp_tick)
  );

  // The comparators are analog and asynchronous, so they are synchronised too
  sync2 #(.W(4)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({bus_halt_ack, irq_pending, precise_reset_cmp, low_supply_cmp}),
    .dout({ack_s, irq_s, prec_s, lvd_s})
  );

  seq_state_type state_q;
  seq_state_type state_d;
  logic sleep_q;
  logic sleep_d;
  logic halt_req_q;
  logic halt_req_d;
  logic pd_q;
  logic pd_d;
  logic prec_smp_q;
  logic prec_smp_d;
  logic lvd_smp_q;
  logic lvd_smp_d;
  logic [7:0] detect_q;
  logic [7:0] detect_d;
  logic [7:0] duty_q;
  logic [7:0] duty_d;
  logic [7:0] rdata_d;
  logic [9:0] duty_cnt_q;
  logic [9:0] duty_cnt_d;
  logic mon_q;
  logic mon_d;
  logic rst_req_d;
  logic lvd_flag_d;
  logic [1:0] level_d;
  logic wr_sleep;
  logic [1:0] level;
  logic [2:0] trip;

  assign level = detect_q[LEVEL_MSB:LEVEL_LSB];
  assign trip = detect_q[TRIP_MSB:TRIP_LSB];
  assign wr_sleep = io_wr && (io_addr == ADDR_SYS_CTRL) && io_wdata[SLEEP_BIT];

  // Sequencer
  always_comb
  begin
    state_d = state_q;
    sleep_d = sleep_q;
    halt_req_d = halt_req_q;
    pd_d = pd_q;
    prec_smp_d = prec_smp_q;
    lvd_smp_d = lvd_smp_q;
    if (io_wr && (io_addr == ADDR_SYS_CTRL))
    begin
      sleep_d = io_wdata[SLEEP_BIT];
    end
    case (state_q)
      ST_RUN:
      begin
        if (wr_sleep)
        begin
          halt_req_d = 1'b1;
          state_d = ST_HALT_REQ;
        end
      end
      ST_HALT_REQ:
      begin
        if (ack_s)
        begin
          state_d = ST_PD_WAIT;
        end
      end
      ST_PD_WAIT:
      begin
        pd_d = 1'b1;
        state_d = ST_ASLEEP;
      end
      ST_ASLEEP:
      begin
        // Global enable is not looked at; the mask is applied upstream
        if (irq_s && lp_tick.fall)
        begin
          state_d = ST_WAKE_PD;
        end
      end
      ST_WAKE_PD:
      begin
        if (lp_tick.rise)
        begin
          pd_d = 1'b0;
          state_d = ST_WAKE_SAMPLE;
        end
      end
      ST_WAKE_SAMPLE:
      begin
        if (lp_tick.rise)
        begin
          prec_smp_d = prec_s;
          lvd_smp_d = lvd_s;
          state_d = ST_WAKE_RELEASE;
        end
      end
      ST_WAKE_RELEASE:
      begin
        if (lp_tick.fall)
        begin
          halt_req_d = 1'b0;
          sleep_d = 1'b0;
          state_d = ST_RUN;
        end
      end
      default:
      begin
        state_d = ST_RUN;
        halt_req_d = 1'b0;
        pd_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_RUN;
      sleep_q <= 1'b0;
      halt_req_q <= 1'b0;
      pd_q <= 1'b0;
      prec_smp_q <= 1'b0;
      lvd_smp_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sleep_q <= sleep_d;
      halt_req_q <= halt_req_d;
      pd_q <= pd_d;
      prec_smp_q <= prec_smp_d;
      lvd_smp_q <= lvd_smp_d;
    end
  end

  // Register file and supply monitor
  always_comb
  begin
    detect_d = detect_q;
    duty_d = duty_q;
    rdata_d = io_rdata_q;
    if (io_wr && (io_addr == ADDR_DETECT_CTRL))
    begin
      detect_d = io_wdata & DETECT_CTRL_MASK;
    end
    if (io_wr && (io_addr == ADDR_DUTY))
    begin
      duty_d = io_wdata & DUTY_MASK;
    end
    if (io_rd)
    begin
      case (io_addr)
        ADDR_SYS_CTRL: rdata_d = {4'h0, sleep_q, 3'h0};
        ADDR_DETECT_CTRL: rdata_d = detect_q;
        ADDR_CMP_STATUS: rdata_d = {6'h00, lvd_flag_d, prec_s};
        ADDR_DUTY: rdata_d = duty_q;
        default: rdata_d = 8'h00;
      endcase
    end
    // Comparator runs one 32 kHz period out of every duty period
    duty_cnt_d = duty_cnt_q;
    mon_d = mon_q;
    if (lp_tick.rise)
    begin
      if (duty_cnt_q >= duty_period(duty_q[DUTY_MSB:DUTY_LSB]) - 10'h001)
      begin
        duty_cnt_d = 10'h000;
      end
      else
      begin
        duty_cnt_d = duty_cnt_q + 10'h001;
      end
      mon_d = (duty_cnt_d == 10'h000);
    end
    // Level 11 keeps the comparator readable at the 3 V setting
    level_d = (level == LEVEL_OFF) ? LEVEL_3V : level;
    rst_req_d = (level != LEVEL_OFF) && prec_s && !pd_q;
    // Reserved trip codes never flag a low supply
    lvd_flag_d = lvd_s && (trip >= TRIP_MIN_VALID);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      detect_q <= REG_RESET;
      duty_q <= REG_RESET;
      io_rdata_q <= REG_RESET;
      duty_cnt_q <= 10'h000;
      mon_q <= 1'b0;
      cmp_level_q <= LEVEL_2V7;
      reset_request_q <= 1'b0;
      low_supply_flag_q <= 1'b0;
    end
    else
    begin
      detect_q <= detect_d;
      duty_q <= duty_d;
      io_rdata_q <= rdata_d;
      duty_cnt_q <= duty_cnt_d;
      mon_q <= mon_d;
      cmp_level_q <= level_d;
      reset_request_q <= rst_req_d;
      low_supply_flag_q <= lvd_flag_d;
    end
  end

  assign bus_halt_request_q = halt_req_q;
  assign system_powerdown_q = pd_q;
  assign precise_reset_flag_q = prec_smp_q;
  assign monitor_on_q = mon_q;

  // Helper: cycles from captured wake interrupt to halt release
  logic [11:0] wake_cnt_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wake_cnt_q <= 12'h000;
    else if (state_q == ST_ASLEEP)
      wake_cnt_q <= 12'h000;
    else if (halt_req_q && wake_cnt_q != 12'hFFF)
      wake_cnt_q <= wake_cnt_q + 12'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_asleep_woken;
    (state_q == ST_ASLEEP) && irq_s && lp_tick.fall;
  endsequence

  sequence s_pd_dropped;
    (state_q == ST_WAKE_PD) && lp_tick.rise;
  endsequence

  a_halt_on_write: assert property ((state_q == ST_RUN) && wr_sleep |=> halt_req_q)
    else $error("halt request not raised by sleep write");
  a_pd_after_ack: assert property ((state_q == ST_HALT_REQ) && ack_s |-> ##2 pd_q)
    else $error("powerdown not asserted after acknowledge");
  a_pd_needs_halt: assert property (pd_q |-> halt_req_q)
    else $error("powerdown without halt request");
  a_wake_only_irq: assert property ((state_q == ST_ASLEEP) && !irq_s
    |=> (state_q == ST_ASLEEP) && pd_q)
    else $error("sleep left without interrupt");
  a_irq_capture: assert property (s_asleep_woken |=> (state_q == ST_WAKE_PD) && pd_q)
    else $error("wake interrupt not captured on fall");
  a_pd_release: assert property (s_pd_dropped |=> !pd_q && halt_req_q)
    else $error("powerdown not dropped on rise");
  a_cmp_sample: assert property ((state_q == ST_WAKE_SAMPLE) && lp_tick.rise
    |=> precise_reset_flag_q == $past(prec_s))
    else $error("comparator not sampled on wake");
  a_halt_release: assert property ((state_q == ST_WAKE_RELEASE) && lp_tick.fall
    |=> !halt_req_q && !sleep_q)
    else $error("halt request not released on fall");
  a_wake_latency: assert property ($fell(halt_req_q) |-> wake_cnt_q <= 12'(WAKE_MAX_CYC))
    else $error("wake sequence too slow");
  a_status_live: assert property (io_rd && io_addr == ADDR_CMP_STATUS
    |=> io_rdata_q == {6'h00, $past(lvd_flag_d), $past(prec_s)})
    else $error("status read not live");
  a_reset_off: assert property (level == LEVEL_OFF |=> !reset_request_q && cmp_level_q == LEVEL_3V)
    else $error("reset generated while disabled");
  a_trip_reserved: assert property (trip < TRIP_MIN_VALID |=> !low_supply_flag_q)
    else $error("reserved trip code flagged low supply");
endmodule

// ### src/sleep_wake_pkg.sv
// Constants, register map and state codes of the sleep and wake sequencer.
// Assumes a single 25 MHz system clock that also stands for the core clock.
package sleep_wake_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int LP_HZ = 32_768;
  // 32 kHz edges become enable pulses; one low-power period in system cycles
  localparam int LP_DIV = CLK_HZ / LP_HZ;
  localparam int LP_HALF = LP_DIV / 2;

  // Wake latency window, interrupt to running core
  localparam int WAKE_MIN_US = 75;
  localparam int WAKE_MAX_US = 105;
  localparam int WAKE_MAX_CYC = WAKE_MAX_US * (CLK_HZ / 1_000_000);

  // Nine-bit I/O address: bit 8 is the second I/O bank
  localparam logic [8:0] ADDR_SYS_CTRL = 9'h0FF;
  localparam logic [8:0] ADDR_DETECT_CTRL = 9'h1E3;
  localparam logic [8:0] ADDR_CMP_STATUS = 9'h1E4;
  localparam logic [8:0] ADDR_DUTY = 9'h1EB;

  localparam int SLEEP_BIT = 3;
  localparam int LEVEL_LSB = 4;
  localparam int LEVEL_MSB = 5;
  localparam int TRIP_LSB = 0;
  localparam int TRIP_MSB = 2;
  localparam int DUTY_LSB = 6;
  localparam int DUTY_MSB = 7;
  localparam int STAT_PREC = 0;
  localparam int STAT_LVD = 1;

  localparam logic [7:0] DETECT_CTRL_MASK = 8'h37;
  localparam logic [7:0] DUTY_MASK = 8'hC0;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [1:0] LEVEL_2V7 = 2'h0;
  localparam logic [1:0] LEVEL_3V = 2'h1;
  localparam logic [1:0] LEVEL_5V = 2'h2;
  localparam logic [1:0] LEVEL_OFF = 2'h3;
  localparam logic [2:0] TRIP_MIN_VALID = 3'h4;

  localparam logic [9:0] DUTY_PER_00 = 10'h080;
  localparam logic [9:0] DUTY_PER_01 = 10'h200;
  localparam logic [9:0] DUTY_PER_10 = 10'h020;
  localparam logic [9:0] DUTY_PER_11 = 10'h008;

  typedef enum logic [6:0] {
    ST_RUN = 7'b0000001,
    ST_HALT_REQ = 7'b0000010,
    ST_PD_WAIT = 7'b0000100,
    ST_ASLEEP = 7'b0001000,
    ST_WAKE_PD = 7'b0010000,
    ST_WAKE_SAMPLE = 7'b0100000,
    ST_WAKE_RELEASE = 7'b1000000
  } seq_state_type;

  // Supply-monitor period in 32 kHz periods for a duty code
  function automatic logic [9:0] duty_period(input logic [1:0] code);
    case (code)
      2'h0: duty_period = DUTY_PER_00;
      2'h1: duty_period = DUTY_PER_01;
      2'h2: duty_period = DUTY_PER_10;
      default: duty_period = DUTY_PER_11;
    endcase
  endfunction

endpackage

// ### src/lp_tick_if.sv
// Carrier for the 32 kHz rising and falling edge enables.
// Both pulses last one system clock cycle.
`timescale 1ns/1ps
interface lp_tick_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport snk (input rise, input fall);
endinterface

// ### src/lp_tick_gen.sv
// Divider that turns the system clock into 32 kHz edge enables.
// Assumes the low-power oscillator is modelled as a fraction of clk.
`timescale 1ns/1ps
module lp_tick_gen
  import sleep_wake_pkg::*;
#(
  parameter int DIV = sleep_wake_pkg::LP_DIV
)
(
  input wire logic clk,
  input wire logic resetn,
  lp_tick_if.src tick
);
  import sleep_wake_pkg::*;

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;

  always_comb
  begin
    cnt_d = (cnt_q == 12'(DIV - 1)) ? 12'h000 : 12'(cnt_q + 12'h001);
    rise_d = (cnt_q == 12'(DIV - 1));
    fall_d = (cnt_q == 12'(DIV / 2 - 1));
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 12'h000;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign tick.rise = rise_q;
  assign tick.fall = fall_q;
endmodule

// ### src/sync2.sv
// Two-stage synchroniser for levels entering the system clock domain.
// The first stage feeds only the second one.
`timescale 1ns/1ps
module sync2
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stage_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      stage_q <= '0;
    end
    else
    begin
      meta_q <= din;
      stage_q <= meta_q;
    end
  end

  assign dout = stage_q;
endmodule

// ### testbench/core_model.sv
// CPU core stand-in that answers the bus halt handshake.
// Assumes it runs on clk, which stands for the core clock.
`timescale 1ns/1ps
module core_model
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_halt_request,
  output logic bus_halt_ack,
  output logic core_running
);
  logic ack_d;
  // Request is looked at only on rising edges, so the answer lags one edge
  always_comb
  begin
    ack_d = bus_halt_request;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_halt_ack <= 1'b0;
    else
      bus_halt_ack <= ack_d;
  end
  // Next instruction runs as soon as acknowledge drops
  assign core_running = !bus_halt_ack;
endmodule

// ### testbench/test_sleep_wake_supply_monitor.sv
// Self-checking bench for the sleep and wake sequencer and its registers.
// Assumes the bench acts as firmware on the I/O port and drives on falling edges.
`timescale 1ns/1ps
module test_sleep_wake_supply_monitor;
  import sleep_wake_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [8:0] io_addr = 9'h000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic irq_pending = 1'b0;
  logic precise_reset_cmp = 1'b0;
  logic low_supply_cmp = 1'b0;
  logic [7:0] io_rdata_q;
  logic bus_halt_ack;
  logic bus_halt_request_q;
  logic system_powerdown_q;
  logic [1:0] cmp_level_q;
  logic reset_request_q;
  logic low_supply_flag_q;
  logic precise_reset_flag_q;
  logic monitor_on_q;
  logic core_running;
  logic [15:0] seed = 16'hD736;
  logic [7:0] v;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int det_m = 0;
  int duty_m = 0;

  sleep_wake_supply_monitor u_dut (.clk(clk), .resetn(resetn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
    .bus_halt_ack(bus_halt_ack), .irq_pending(irq_pending),
    .precise_reset_cmp(precise_reset_cmp), .low_supply_cmp(low_supply_cmp),
    .bus_halt_request_q(bus_halt_request_q), .system_powerdown_q(system_powerdown_q),
    .cmp_level_q(cmp_level_q), .reset_request_q(reset_request_q),
    .low_supply_flag_q(low_supply_flag_q), .precise_reset_flag_q(precise_reset_flag_q),
    .monitor_on_q(monitor_on_q));

  core_model u_core (.clk(clk), .resetn(resetn), .bus_halt_request(bus_halt_request_q),
    .bus_halt_ack(bus_halt_ack), .core_running(core_running));

  always #20 clk = ~clk;

  // Hang guard: all scenarios together need well under this many cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      end_of_test();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bank two is reached through addr[8], as firmware must select it first
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    if (a == ADDR_DETECT_CTRL)
      det_m = int'(d & DETECT_CTRL_MASK);
    if (a == ADDR_DUTY)
      duty_m = int'(d & DUTY_MASK);
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata_q;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic sleep_wake(input logic pcmp);
    int t;
    int tp;
    begin
      precise_reset_cmp = pcmp;
      wr(ADDR_SYS_CTRL, 8'h08);
      cmp("halt request", 8'h01, {7'h00, bus_halt_request_q});
      t = 0;
      while (system_powerdown_q !== 1'b1 && t < 20)
      begin
        idle(1);
        t++;
      end
      cmp("powerdown rise", 8'h01, {7'h00, system_powerdown_q});
      idle(100);
      cmp("still asleep", 8'h03,
        {5'h00, core_running, bus_halt_request_q, system_powerdown_q});
      irq_pending = 1'b1;
      t = 0;
      tp = -1;
      while (bus_halt_request_q !== 1'b0 && t < WAKE_MAX_CYC + 10)
      begin
        idle(1);
        t++;
        if (tp < 0 && system_powerdown_q === 1'b0)
          tp = t;
      end
      irq_pending = 1'b0;
      cmp("wake in time", 8'h01, {7'h00, t <= WAKE_MAX_CYC});
      cmp("pd before release", 8'h01, {7'h00, tp > 0 && t - tp >= LP_DIV});
      cmp("sampled reset", {7'h00, pcmp}, {7'h00, precise_reset_flag_q});
      idle(2);
      cmp("ack dropped", 8'h00, {7'h00, bus_halt_ack});
      cmp("core resumed", 8'h01, {7'h00, core_running});
      rd(ADDR_SYS_CTRL, v);
      cmp("sleep bit clear", 8'h00, v & 8'h08);
      precise_reset_cmp = 1'b0;
      $display("test sleep_wake done");
    end
  endtask

  // Code 11 keeps the run short: one on period out of every eight
  task automatic duty_check();
    int t;
    int hi;
    int per;
    int exp_per;
    begin
      exp_per = int'(DUTY_PER_11) * LP_DIV;
      wr(ADDR_DUTY, 8'hC0);
      t = 0;
      while (monitor_on_q !== 1'b0 && t < 2 * LP_DIV)
      begin
        idle(1);
        t++;
      end
      t = 0;
      while (monitor_on_q !== 1'b1 && t < 10 * LP_DIV)
      begin
        idle(1);
        t++;
      end
      hi = 0;
      while (monitor_on_q === 1'b1 && hi < 2 * LP_DIV)
      begin
        idle(1);
        hi++;
      end
      per = hi;
      while (monitor_on_q !== 1'b1 && per < 10 * LP_DIV)
      begin
        idle(1);
        per++;
      end
      cmp("monitor on time", 8'h01, {7'h00, hi == LP_DIV});
      cmp("monitor period", 8'h01, {7'h00, per == exp_per});
      $display("test duty done");
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    rd(ADDR_DETECT_CTRL, v);
    cmp("detect reset", REG_RESET, v);
    rd(ADDR_CMP_STATUS, v);
    cmp("status reset", REG_RESET, v);
    rd(ADDR_DUTY, v);
    cmp("duty reset", REG_RESET, v);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      wr(ADDR_DETECT_CTRL, seed[7:0]);
      wr(ADDR_DUTY, seed[15:8]);
      wr(9'h1E5, seed[15:8]);
      rd(ADDR_DETECT_CTRL, v);
      cmp("detect ctrl", 8'(det_m), v);
      rd(ADDR_DUTY, v);
      cmp("duty trim", 8'(duty_m), v);
      rd(9'h1E5, v);
      cmp("unmapped", 8'h00, v);
    end
    $display("test register_access done");
    low_supply_cmp = 1'b1;
    precise_reset_cmp = 1'b1;
    for (int tr = 0; tr < 8; tr++)
    begin
      seed = lfsr(seed);
      wr(ADDR_DETECT_CTRL, 8'(tr));
      wr(ADDR_CMP_STATUS, seed[7:0]);
      idle(4);
      rd(ADDR_CMP_STATUS, v);
      cmp("status", {6'h00, tr >= 4, 1'b1}, v);
      cmp("low flag", {7'h00, tr >= 4}, {7'h00, low_supply_flag_q});
    end
    low_supply_cmp = 1'b0;
    idle(4);
    rd(ADDR_CMP_STATUS, v);
    cmp("status live", 8'h01, v);
    $display("test status done");
    for (int lv = 0; lv < 4; lv++)
    begin
      wr(ADDR_DETECT_CTRL, 8'(lv * 16 + 4));
      idle(5);
      cmp("level out", (lv == 3) ? 8'h01 : 8'(lv), {6'h00, cmp_level_q});
      cmp("reset req", {7'h00, lv != 3}, {7'h00, reset_request_q});
    end
    precise_reset_cmp = 1'b0;
    wr(ADDR_DETECT_CTRL, 8'h34);
    $display("test levels done");
    sleep_wake(1'b0);
    sleep_wake(1'b1);
    duty_check();
    end_of_test();
  end
endmodule
